// ### logic/timer16_regs.svh
`ifndef TIMER16_REGS_SVH
`define TIMER16_REGS_SVH

// =====================================================================
// Register byte offsets
`define OFS_OUT_PWM_CTRL 8'h00
`define OFS_CAP_CLK_CTRL 8'h04
`define OFS_COUNT 8'h08
`define OFS_COMPARE 8'h0C
`define OFS_CAPTURE 8'h10
`define OFS_FLAGS 8'h14
`define OFS_MASK 8'h18
`define OFS_PIN_CTRL 8'h1C

// =====================================================================
// Field positions
`define MATCH_ACT_HI 7
`define MATCH_ACT_LO 6
`define PWM_SEL_HI 1
`define PWM_SEL_LO 0
`define NOISE_EN_BIT 7
`define EDGE_SEL_BIT 6
`define CLR_MATCH_BIT 3
`define CLK_SEL_HI 2
`define CLK_SEL_LO 0
`define CTRL_A_MASK 8'hC3
`define CTRL_B_MASK 8'hCF
`define FLAG_OVF 0
`define FLAG_MATCH 1
`define FLAG_CAP 2
`define PIN_CMP_DIR 0
`define PIN_CNT_DIR 1
`define PIN_CNT_OUT 2
`define PIN_CAP_SRC 3

// =====================================================================
// Reset values and counts
`define RST_CTRL 8'h00
`define RST_WORD 16'h0000
`define TOP_NORMAL 16'hFFFF
`define TOP_PWM8 16'h00FF
`define TOP_PWM9 16'h01FF
`define TOP_PWM_SEL_LO 16'h03FF
`define NOISE_SAMPLES 4

`endif

// ### logic/timer16_pkg.sv
package timer16_pkg;

    typedef enum logic [2:0] {
        CLK_STOP, CLK_DIV1, CLK_DIV8, CLK_DIV64,
        CLK_DIV256, CLK_DIV1024, CLK_EXT_FALL, CLK_EXT_RISE
    } clk_sel_t;

    typedef enum {DIR_UP, DIR_DOWN} count_dir_t;

    typedef struct packed {
        logic capture;
        logic match;
        logic overflow;
    } flags_t;

    typedef struct packed {
        logic cap_src_cmp;
        logic cnt_out;
        logic cnt_dir;
        logic cmp_dir;
    } pin_ctrl_t;

endpackage

// ### logic/timer16_compare_capture.sv
`timescale 1ns/1ps
`include "timer16_regs.svh"

// Behaviour
// - Clock select: stop, CK, CK/8/64/256/1024, pin falling or rising edge
// - External count pin sampled on CPU clock rising edge before edge detect
// - Count pin edges advance counter even when pin is an output
// - Software write loads counter; counting resumes next timer tick
// - Counter continuously compared; match may clear it and act on pin
// - Match action field: off, toggle, drive low, drive high
// - Compare output reaches pin only when its direction bit is output
// - PWM select: off, 8-bit, 9-bit, 10-bit; action field changes meaning
// - PWM gives glitch-free centred pulses on compare output
// - Up-only outside PWM; up and down alternately in PWM
// - Clear-on-match resets counter to zero on the timer tick after match
// - Undivided clock with compare C counts C-1, C, 0, 1
// - Clear-on-match has no effect in PWM modes
// - Selected capture edge copies counter into capture register
// - Noise filter requires four equal samples before capture
// - Comparator output may replace capture pin as capture source
// - Overflow, match and capture flags, each gated by mask register
// - Reserved control bits read as zero
module timer16_compare_capture
    import timer16_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic count_in_pin_i,
    output logic count_in_pin_o,
    output logic count_in_pin_oe_o,
    input wire logic capture_pin_i,
    input wire logic comparator_out_i,
    output logic compare_out_pin_o,
    output logic compare_out_pin_oe_o,
    output logic [2:0] irq_req_o
);

    // =================================================================
    // Registers
    logic [7:0] ctrl_a_reg;
    logic [7:0] ctrl_b_reg;
    logic [15:0] count_reg;
    logic [15:0] compare_reg;
    logic [15:0] compare_buf_reg;
    logic [15:0] capture_reg;
    flags_t flags_reg;
    flags_t mask_reg;
    pin_ctrl_t pin_reg;
    count_dir_t dir_reg;

    logic bus_wr;
    logic wr_ctrl_a, wr_ctrl_b, wr_count, wr_compare;
    logic wr_flags, wr_mask, wr_pin;
    logic addr_ok;
    logic [31:0] rd_next;

    assign bus_wr = psel_i && penable_i && pready_o && pwrite_i && ce_i;
    assign wr_ctrl_a = bus_wr && paddr_i == `OFS_OUT_PWM_CTRL;
    assign wr_ctrl_b = bus_wr && paddr_i == `OFS_CAP_CLK_CTRL;
    assign wr_count = bus_wr && paddr_i == `OFS_COUNT;
    assign wr_compare = bus_wr && paddr_i == `OFS_COMPARE;
    assign wr_flags = bus_wr && paddr_i == `OFS_FLAGS;
    assign wr_mask = bus_wr && paddr_i == `OFS_MASK;
    assign wr_pin = bus_wr && paddr_i == `OFS_PIN_CTRL;

    always_comb begin
        addr_ok = 1'b1;
        rd_next = 32'h0000_0000;
        case (paddr_i)
            `OFS_OUT_PWM_CTRL: rd_next[7:0] = ctrl_a_reg;
            `OFS_CAP_CLK_CTRL: rd_next[7:0] = ctrl_b_reg;
            `OFS_COUNT: rd_next[15:0] = count_reg;
            `OFS_COMPARE: rd_next[15:0] = compare_reg;
            `OFS_CAPTURE: rd_next[15:0] = capture_reg;
            `OFS_FLAGS: rd_next[2:0] = flags_reg;
            `OFS_MASK: rd_next[2:0] = mask_reg;
            `OFS_PIN_CTRL: rd_next[3:0] = pin_reg;
            default: addr_ok = 1'b0;
        endcase
    end

    // =================================================================
    // APB slave: answer prepared in the setup cycle, so no wait state
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end else if (ce_i) begin
            pready_o <= psel_i && !penable_i;
            pslverr_o <= psel_i && !penable_i && !addr_ok;
            prdata_o <= (psel_i && !penable_i) ? rd_next : 32'h0000_0000;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_a_reg <= `RST_CTRL;
            ctrl_b_reg <= `RST_CTRL;
            compare_reg <= `RST_WORD;
            mask_reg <= '0;
            pin_reg <= '0;
        end else if (ce_i) begin
            // Reserved bits never stored
            if (wr_ctrl_a)
                ctrl_a_reg <= pwdata_i[7:0] & `CTRL_A_MASK;
            if (wr_ctrl_b)
                ctrl_b_reg <= pwdata_i[7:0] & `CTRL_B_MASK;
            if (wr_compare)
                compare_reg <= pwdata_i[15:0];
            if (wr_mask)
                mask_reg <= pwdata_i[2:0];
            if (wr_pin)
                pin_reg <= pwdata_i[3:0];
        end
    end

    // =================================================================
    // Decoded controls
    clk_sel_t clk_sel;
    logic [1:0] pwm_sel, match_act;
    logic pwm_on, clr_on_match, noise_en, edge_rise;
    logic [15:0] top;

    assign clk_sel = clk_sel_t'(ctrl_b_reg[`CLK_SEL_HI:`CLK_SEL_LO]);
    assign pwm_sel = ctrl_a_reg[`PWM_SEL_HI:`PWM_SEL_LO];
    assign match_act = ctrl_a_reg[`MATCH_ACT_HI:`MATCH_ACT_LO];
    assign pwm_on = pwm_sel != 2'h0;
    assign clr_on_match = ctrl_b_reg[`CLR_MATCH_BIT] && !pwm_on;
    assign noise_en = ctrl_b_reg[`NOISE_EN_BIT];
    assign edge_rise = ctrl_b_reg[`EDGE_SEL_BIT];

    always_comb begin
        case (pwm_sel)
            2'h1: top = `TOP_PWM8;
            2'h2: top = `TOP_PWM9;
            2'h3: top = `TOP_PWM_SEL_LO;
            default: top = `TOP_NORMAL;
        endcase
    end

    // =================================================================
    // Pin synchronisers and prescaler
    logic [1:0] cnt_sync, cap_sync, cmp_sync;
    logic cnt_prev;
    logic [9:0] presc_reg;

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_sync <= 2'h0;
            cap_sync <= 2'h0;
            cmp_sync <= 2'h0;
            cnt_prev <= 1'b0;
        end else if (ce_i) begin
            // Pin read back, so software driving it as output still counts
            cnt_sync <= {cnt_sync[0], count_in_pin_i};
            cap_sync <= {cap_sync[0], capture_pin_i};
            cmp_sync <= {cmp_sync[0], comparator_out_i};
            cnt_prev <= cnt_sync[1];
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i)
            presc_reg <= 10'h000;
        else if (ce_i)
            presc_reg <= presc_reg + 10'h001;
    end

    logic tick;
    always_comb begin
        case (clk_sel)
            CLK_STOP: tick = 1'b0;
            CLK_DIV1: tick = 1'b1;
            CLK_DIV8: tick = &presc_reg[2:0];
            CLK_DIV64: tick = &presc_reg[5:0];
            CLK_DIV256: tick = &presc_reg[7:0];
            CLK_DIV1024: tick = &presc_reg[9:0];
            // Edge caught only if pin holds a level for a clock
            CLK_EXT_FALL: tick = cnt_prev && !cnt_sync[1];
            CLK_EXT_RISE: tick = !cnt_prev && cnt_sync[1];
            default: tick = 1'b0;
        endcase
    end

    // =================================================================
    // Counter and compare
    logic match_now, match_prev, match_evt;
    logic at_top, at_bottom, wrap_evt;
    logic [15:0] cmp_eff;

    // PWM compares against a copy refreshed only at top: no glitches
    assign cmp_eff = pwm_on ? compare_buf_reg : compare_reg;
    assign match_now = count_reg == cmp_eff;
    assign match_evt = match_now && !match_prev;
    assign at_top = count_reg == top;
    assign at_bottom = count_reg == 16'h0000;
    assign wrap_evt = tick && !wr_count && !pwm_on && at_top
        && !(clr_on_match && match_now);

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            count_reg <= `RST_WORD;
            dir_reg <= DIR_UP;
        end else if (ce_i) begin
            if (wr_count) begin
                count_reg <= pwdata_i[15:0];
            end else if (tick) begin
                if (!pwm_on) begin
                    dir_reg <= DIR_UP;
                    if (clr_on_match && match_now)
                        count_reg <= 16'h0000;
                    else
                        count_reg <= count_reg + 16'h0001;
                end else begin
                    case (dir_reg)
                        DIR_UP: begin
                            if (count_reg >= top) begin
                                dir_reg <= DIR_DOWN;
                                count_reg <= top - 16'h0001;
                            end else begin
                                count_reg <= count_reg + 16'h0001;
                            end
                        end
                        DIR_DOWN: begin
                            if (at_bottom) begin
                                dir_reg <= DIR_UP;
                                count_reg <= 16'h0001;
                            end else begin
                                count_reg <= count_reg - 16'h0001;
                            end
                        end
                        default: dir_reg <= DIR_UP;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            compare_buf_reg <= `RST_WORD;
            // Reset count equals reset compare: no false match event
            match_prev <= 1'b1;
        end else if (ce_i) begin
            match_prev <= match_now;
            if (!pwm_on || (tick && at_top))
                compare_buf_reg <= compare_reg;
        end
    end

    // =================================================================
    // Compare output pin
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            compare_out_pin_o <= 1'b0;
        end else if (ce_i && match_evt) begin
            if (!pwm_on) begin
                case (match_act)
                    2'h1: compare_out_pin_o <= !compare_out_pin_o;
                    2'h2: compare_out_pin_o <= 1'b0;
                    2'h3: compare_out_pin_o <= 1'b1;
                    default: compare_out_pin_o <= compare_out_pin_o;
                endcase
            end else if (match_act[1]) begin
                // Centred pulse: opposite levels up and down
                compare_out_pin_o <= (dir_reg == DIR_UP) ^ !match_act[0];
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            compare_out_pin_oe_o <= 1'b0;
            count_in_pin_o <= 1'b0;
            count_in_pin_oe_o <= 1'b0;
        end else if (ce_i) begin
            compare_out_pin_oe_o <= pin_reg.cmp_dir
                && (pwm_on ? match_act[1] : match_act != 2'h0);
            count_in_pin_o <= pin_reg.cnt_out;
            count_in_pin_oe_o <= pin_reg.cnt_dir;
        end
    end

    // =================================================================
    // Input capture
    logic cap_sample, lvl_reg, lvl_next, cap_evt;
    logic [`NOISE_SAMPLES-1:0] hist_reg;

    assign cap_sample = pin_reg.cap_src_cmp ? cmp_sync[1]
        : cap_sync[1];

    always_comb begin
        lvl_next = lvl_reg;
        if (!noise_en)
            lvl_next = cap_sample;
        else if (&hist_reg)
            lvl_next = 1'b1;
        else if (~|hist_reg)
            lvl_next = 1'b0;
    end

    assign cap_evt = (lvl_next != lvl_reg)
        && (lvl_next == edge_rise);

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hist_reg <= '0;
            lvl_reg <= 1'b0;
            capture_reg <= `RST_WORD;
        end else if (ce_i) begin
            hist_reg <= {hist_reg[`NOISE_SAMPLES-2:0], cap_sample};
            lvl_reg <= lvl_next;
            if (cap_evt)
                capture_reg <= count_reg;
        end
    end

    // =================================================================
    // Flags: write one to clear, a new event wins over the clear
    flags_t set_now;
    logic pwm_bottom;
    assign pwm_bottom = pwm_on && tick && !wr_count
        && dir_reg == DIR_DOWN && count_reg == 16'h0001;
    assign set_now = '{capture: cap_evt, match: match_evt,
        overflow: wrap_evt || pwm_bottom};

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            flags_reg <= '0;
            irq_req_o <= 3'h0;
        end else if (ce_i) begin
            flags_reg <= (flags_reg & ~(wr_flags ? pwdata_i[2:0] : 3'h0))
                | set_now;
            irq_req_o <= flags_reg & mask_reg;
        end
    end

    // =================================================================
    // Checks
    a_setup_ready: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        ce_i && psel_i && !penable_i |=> pready_o)
        else $error("no answer after setup");
    a_match_clear: assert property (
        @(posedge mclk_i) disable iff (!rstn_i)
        ce_i && tick && !wr_count && !pwm_on && clr_on_match && match_now
        |=> count_reg == 16'h0000)
        else $error("counter not cleared on match");
    a_pwm_no_clear: assert property (
        @(posedge mclk_i) disable iff (!rstn_i)
        ce_i && pwm_on && tick && !wr_count && dir_reg == DIR_UP
        && count_reg < top |=> count_reg == $past(count_reg) + 16'h0001)
        else $error("pwm up count wrong");
    a_stop_hold: assert property (
        @(posedge mclk_i) disable iff (!rstn_i)
        ce_i && clk_sel == CLK_STOP && !wr_count |=> $stable(count_reg))
        else $error("stopped counter moved");
    a_wrap_flag: assert property (
        @(posedge mclk_i) disable iff (!rstn_i)
        ce_i && !pwm_on && tick && !wr_count && count_reg == 16'hFFFF
        && !(clr_on_match && match_now)
        |=> count_reg == 16'h0000 ##1 irq_req_o[0] || !mask_reg.overflow)
        else $error("wrap not flagged");
    a_capture_copy: assert property (
        @(posedge mclk_i) disable iff (!rstn_i)
        ce_i && cap_evt |=> capture_reg == $past(count_reg)
        && flags_reg.capture)
        else $error("capture value wrong");
    a_load_write: assert property (
        @(posedge mclk_i) disable iff (!rstn_i)
        wr_count |=> count_reg == $past(pwdata_i[15:0]))
        else $error("counter write lost");
    a_pin_dir: assert property (
        @(posedge mclk_i) disable iff (!rstn_i)
        ce_i && !pin_reg.cmp_dir |=> !compare_out_pin_oe_o)
        else $error("compare pin driven while input");
    a_reserved_zero: assert property (
        @(posedge mclk_i) disable iff (!rstn_i)
        pready_o && psel_i && paddr_i == `OFS_OUT_PWM_CTRL
        |-> prdata_o[5:2] == 4'h0)
        else $error("reserved bits read nonzero");
    a_noise_hold: assert property (
        @(posedge mclk_i) disable iff (!rstn_i)
        ce_i && noise_en && cap_evt |-> hist_reg == {4{edge_rise}})
        else $error("capture before four samples agree");

endmodule // timer16_compare_capture

// ### verif/timer16_pins_model.sv
`timescale 1ns/1ps

// =====================================================================
// Outside drivers of the count, capture and comparator lines
module timer16_pins_model (
    input wire logic mclk_i,
    output logic count_lvl_o,
    output logic capture_lvl_o,
    output logic comparator_lvl_o
);
    initial begin
        count_lvl_o = 1'b0;
        capture_lvl_o = 1'b0;
        comparator_lvl_o = 1'b0;
    end

    // Two cycles per level, above the one-cycle minimum spacing
    task automatic count_pulses(input int n);
        for (int i = 0; i < n; i++) begin
            repeat (2) @(posedge mclk_i);
            count_lvl_o <= 1'b1;
            repeat (2) @(posedge mclk_i);
            count_lvl_o <= 1'b0;
        end
    endtask

    task automatic capture_set(input logic lvl, input int hold);
        @(posedge mclk_i);
        capture_lvl_o <= lvl;
        repeat (hold) @(posedge mclk_i);
    endtask

    task automatic comparator_set(input logic lvl);
        @(posedge mclk_i);
        comparator_lvl_o <= lvl;
    endtask
endmodule // timer16_pins_model

// ### verif/timer16_compare_capture_tb.sv
`timescale 1ns/1ps
`include "timer16_regs.svh"

module timer16_compare_capture_tb
    import timer16_pkg::*;
;
    localparam logic [7:0] ra = `OFS_OUT_PWM_CTRL;
    localparam logic [7:0] rb = `OFS_CAP_CLK_CTRL;
    localparam logic [7:0] rc = `OFS_COUNT;
    localparam logic [7:0] rm = `OFS_COMPARE;
    localparam logic [7:0] rp = `OFS_CAPTURE;
    localparam logic [7:0] rf = `OFS_FLAGS;
    localparam logic [7:0] rk = `OFS_MASK;
    localparam logic [7:0] rx = `OFS_PIN_CTRL;
    int dv[6] = '{0, 1, 8, 64, 256, 1024};
    int acts[4] = '{3, 1, 1, 2};

    logic mclk_i, rstn_i, psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, v, mx, prev, cv;
    logic pready, pslverr, rerr, dn, pin_exp, ce;
    logic cnt_out, cnt_oe, cnt_lvl, cap_lvl, cmp_lvl, cmp_pin, cmp_oe;
    logic cnt_wire;
    logic [2:0] irq;
    logic [15:0] lfsr;
    int error_cnt, total_checks, n;

    // Count line follows the design while its enable is high
    assign cnt_wire = cnt_oe ? cnt_out : cnt_lvl;

    timer16_compare_capture DUT (.mclk_i(mclk_i), .rstn_i(rstn_i),
        .ce_i(ce), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .count_in_pin_i(cnt_wire),
        .count_in_pin_o(cnt_out), .count_in_pin_oe_o(cnt_oe),
        .capture_pin_i(cap_lvl), .comparator_out_i(cmp_lvl),
        .compare_out_pin_o(cmp_pin), .compare_out_pin_oe_o(cmp_oe),
        .irq_req_o(irq));

    timer16_pins_model pins (.mclk_i(mclk_i), .count_lvl_o(cnt_lvl),
        .capture_lvl_o(cap_lvl), .comparator_lvl_o(cmp_lvl));

    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    // =================================================================
    // Helpers
    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic exp_pin(input int act, input logic old);
        case (act)
            1: return ~old;
            2: return 1'b0;
            3: return 1'b1;
            default: return old;
        endcase
    endfunction

    function automatic logic [31:0] pwm_top(input int m);
        return (m == 1) ? 32'h0000_00FF : (m == 2) ? 32'h0000_01FF
                                                   : 32'h0000_03FF;
    endfunction

    function automatic logic [31:0] inr(input logic [31:0] x, lo, hi);
        return 32'(x >= lo && x <= hi);
    endfunction

    task automatic close_out();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        @(posedge mclk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_i);
        penable <= 1'b1;
        do begin
            @(posedge mclk_i);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            error_cnt++;
            close_out();
        end
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, e);
    endtask

    task automatic wait_cyc(input int c);
        repeat (c) @(posedge mclk_i);
    endtask

    // =================================================================
    // Main sequence
    initial begin
        {psel, penable, pwrite, rstn_i} = 4'h0;
        ce = 1'b1;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        error_cnt = 0;
        total_checks = 0;
        lfsr = 16'h1B4C;
        pin_exp = 1'b0;
        wait_cyc(4);
        rstn_i <= 1'b1;
        for (int i = 0; i < 8; i++) rdchk(8'(4 * i), 32'h0000_0000);
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk(32'(rerr), 32'h0000_0001);
        wr(ra, 32'h0000_00FF);
        rdchk(ra, 32'h0000_00C3);
        wr(rb, 32'h0000_00FF);
        rdchk(rb, 32'h0000_00CF);
        wr(ra, 32'h0000_0000);
        wr(rb, 32'h0000_0000);
        // Internal rates: tick count over a known span, one tick slack
        for (int c = 1; c < 6; c++) begin
            wr(rc, 32'h0000_0000);
            wr(rb, 32'(c));
            wait_cyc(4 * dv[c]);
            wr(rb, 32'h0000_0000);
            apb(1'b0, rc, 32'h0000_0000);
            v = (4 * dv[c] + 3) / dv[c];
            chk(inr(rd, v - 1, v + 1), 32'h0000_0001);
        end
        wait_cyc(10);
        rdchk(rc, rd);
        // External edges, then pin driven by the design itself
        for (int m = 6; m < 8; m++) begin
            lfsr = nxt(lfsr);
            n = 1 + lfsr[2:0];
            wr(rc, 32'h0000_0000);
            wr(rb, 32'(m));
            pins.count_pulses(n);
            wait_cyc(6);
            wr(rb, 32'h0000_0000);
            rdchk(rc, 32'(n));
        end
        wr(rx, 32'h0000_0002);
        wr(rc, 32'h0000_0000);
        wr(rb, 32'h0000_0007);
        for (int i = 0; i < 3; i++) begin
            wr(rx, 32'h0000_0006);
            wr(rx, 32'h0000_0002);
        end
        wait_cyc(4);
        wr(rb, 32'h0000_0000);
        rdchk(rc, 32'h0000_0003);
        wr(rx, 32'h0000_0000);
        // Load while running
        lfsr = nxt(lfsr);
        v = {17'h0_0000, lfsr[14:0]};
        wr(rb, 32'h0000_0001);
        wr(rc, v);
        wait_cyc(10);
        // Enable low freezes the count, so the tick total stays the same
        ce <= 1'b0;
        wait_cyc(20);
        ce <= 1'b1;
        wr(rb, 32'h0000_0000);
        apb(1'b0, rc, 32'h0000_0000);
        chk(inr(rd, v + 11, v + 14), 32'h0000_0001);
        // Clear on match, flags and mask
        lfsr = nxt(lfsr);
        cv = 32'(20 + lfsr[6:0]);
        wr(rm, cv);
        wr(rc, 32'h0000_0000);
        wr(rf, 32'h0000_0007);
        wr(rb, 32'h0000_0009);
        wait_cyc(cv + 10);
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, rc, 32'h0000_0000);
            chk(inr(rd, 0, cv), 32'h0000_0001);
        end
        wr(rb, 32'h0000_0000);
        apb(1'b0, rf, 32'h0000_0000);
        chk(32'(rd[1]), 32'h0000_0001);
        wr(rk, 32'h0000_0000);
        chk(32'(irq), 32'h0000_0000);
        wr(rk, 32'h0000_0002);
        wait_cyc(2);
        chk(32'(irq), 32'h0000_0002);
        wr(rf, 32'h0000_0002);
        wait_cyc(2);
        chk(32'(irq), 32'h0000_0000);
        wr(rc, 32'h0000_0000);
        wr(rb, 32'h0000_0001);
        wait_cyc(cv + 10);
        wr(rb, 32'h0000_0000);
        apb(1'b0, rc, 32'h0000_0000);
        chk(32'(rd > cv), 32'h0000_0001);
        // Wrap from the top
        wr(rc, 32'h0000_FFF0);
        wr(rf, 32'h0000_0007);
        wr(rk, 32'h0000_0007);
        wr(rb, 32'h0000_0001);
        wait_cyc(30);
        wr(rb, 32'h0000_0000);
        apb(1'b0, rf, 32'h0000_0000);
        chk(32'(rd[0]), 32'h0000_0001);
        chk(32'(irq[0]), 32'h0000_0001);
        // Compare pin actions: set, toggle twice, clear
        wr(rx, 32'h0000_0001);
        for (int i = 0; i < 4; i++) begin
            wr(rm, 32'h0000_0008);
            wr(rc, 32'h0000_0000);
            wr(ra, 32'(acts[i] << 6));
            wr(rb, 32'h0000_0001);
            wait_cyc(20);
            wr(rb, 32'h0000_0000);
            pin_exp = exp_pin(acts[i], pin_exp);
            chk(32'(cmp_pin), 32'(pin_exp));
            chk(32'(cmp_oe), 32'h0000_0001);
        end
        wr(ra, 32'h0000_0000);
        wait_cyc(2);
        chk(32'(cmp_oe), 32'h0000_0000);
        wr(ra, 32'h0000_00C0);
        wr(rx, 32'h0000_0000);
        wait_cyc(2);
        chk(32'(cmp_oe), 32'h0000_0000);
        wr(ra, 32'h0000_0000);
        // Capture: rising, falling, filtered glitch, comparator source
        for (int e = 1; e >= 0; e--) begin
            lfsr = nxt(lfsr);
            v = {16'h0000, lfsr};
            wr(rf, 32'h0000_0007);
            wr(rc, v);
            wr(rb, 32'(e << 6));
            pins.capture_set(e[0], 8);
            rdchk(rp, v);
            apb(1'b0, rf, 32'h0000_0000);
            chk(32'(rd[2]), 32'h0000_0001);
        end
        prev = v;
        lfsr = nxt(lfsr);
        v = {16'h0000, lfsr};
        wr(rc, v);
        wr(rb, 32'h0000_00C0);
        pins.capture_set(1'b1, 1);
        pins.capture_set(1'b0, 8);
        rdchk(rp, prev);
        pins.capture_set(1'b1, 10);
        rdchk(rp, v);
        lfsr = nxt(lfsr);
        v = {16'h0000, lfsr};
        wr(rx, 32'h0000_0008);
        wr(rc, v);
        wr(rb, 32'h0000_0040);
        pins.comparator_set(1'b1);
        wait_cyc(8);
        rdchk(rp, v);
        wr(rx, 32'h0000_0000);
        // PWM widths: bounded, up and down, clear bit ignored
        for (int m = 1; m < 4; m++) begin
            wr(rb, 32'h0000_0000);
            wr(rc, 32'h0000_0000);
            wr(rm, 32'h0000_0010);
            // Action 10: low after up-match, high after down-match
            wr(ra, 32'(m) | 32'h0000_0080);
            wr(rb, 32'h0000_0009);
            mx = 32'h0000_0000;
            prev = 32'h0000_0000;
            dn = 1'b0;
            for (int i = 0; i < 40; i++) begin
                wait_cyc(60);
                apb(1'b0, rc, 32'h0000_0000);
                if (rd < prev) dn = 1'b1;
                if (dn && (rd > 32'h0000_0014 || rd < 32'h0000_000C))
                    chk(32'(cmp_pin), 32'(rd < 32'h0000_000C));
                if (rd > mx) mx = rd;
                prev = rd;
            end
            chk(32'(mx <= pwm_top(m)), 32'h0000_0001);
            chk(32'(mx > 32'h0000_0010), 32'h0000_0001);
            chk(32'(dn), 32'h0000_0001);
        end
        close_out();
    end
endmodule // timer16_compare_capture_tb
